// ---- rtl/pla_pkg.sv ----
/*
  shared constants and types for the link partner ability register bank.
  assumes an apb slave with 32-bit data and a 12-bit byte address.
*/
package pla_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PAGE_W = 16;
  localparam int unsigned IDX_W  = 10;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] ABIL_IDX = 10'h005;
  localparam logic [IDX_W-1:0] CTRL_IDX = 10'h010;
  localparam logic [IDX_W-1:0] STAT_IDX = 10'h011;
  localparam logic [ADDR_W-1:0] ABIL_ADDR = {ABIL_IDX, 2'b00};

  // ability word bit positions
  localparam int unsigned BIT_MORE_PAGES = 15;
  localparam int unsigned BIT_ACK        = 14;
  localparam int unsigned BIT_RSVD       = 12;
  localparam logic [PAGE_W-1:0] ABIL_RST = 16'h0000;

  // control and status fields
  localparam int unsigned CTRL_PG_EN   = 0;
  localparam int unsigned CTRL_RESTART = 1;
  localparam logic CTRL_PG_EN_RST      = 1'b0;
  localparam int unsigned STAT_PG_VIEW = 0;
  localparam int unsigned STAT_BASE    = 1;
  localparam int unsigned STAT_CNT_LO  = 8;
  localparam int unsigned CNT_W        = 8;

  // one received page from the negotiation engine
  typedef struct packed {
    logic              valid;
    logic              next;
    logic [PAGE_W-1:0] word;
  } pla_page_t;

  // base page layout
  typedef struct packed {
    logic       more_pages_wanted;
    logic       ack;
    logic       partner_fault_flag;
    logic       rsvd;
    logic       one_way_flow_ctrl_able;
    logic       pause_able;
    logic       four_pair_fast_able;
    logic       fast_full_able;
    logic       fast_half_able;
    logic       ten_full_able;
    logic       ten_half_able;
    logic [4:0] selector;
  } pla_base_t;

  // next page layout
  typedef struct packed {
    logic        more_pages_wanted;
    logic        ack;
    logic        message_page_flag;
    logic        partner_can_comply;
    logic        toggle;
    logic [10:0] code;
  } pla_next_t;

  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pla_apb_req_t;

  typedef struct packed {
    logic              stb;
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] data;
  } pla_wr_t;

  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] i;
    i = a[ADDR_W-1:2];
    return (a[1:0] == 2'b00) && (i == ABIL_IDX || i == CTRL_IDX || i == STAT_IDX);
  endfunction

endpackage

// ---- rtl/pla_apb_slave.sv ----
/*
  apb slave front end: one wait state, registered answer.
  assumes the parent supplies read data for the current address
  combinationally and accepts a one-cycle write strobe.
*/
`timescale 1ns/1ps
module pla_apb_slave (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire pla_pkg::pla_apb_req_t    req,
  input  wire logic [pla_pkg::DATA_W-1:0] rd_data,
  output logic      [pla_pkg::DATA_W-1:0] prdata_ff,
  output logic                          pready_ff,
  output logic                          pslverr_ff,
  output pla_pkg::pla_wr_t              wr
);

  logic access_wait;
  logic hit;

  // first access cycle still waiting for the registered answer
  assign access_wait = req.sel && req.enable && !pready_ff;
  assign hit         = pla_pkg::reg_hit(req.addr);

  //////////////////////////////////////////////////////////////////////
  // answer one cycle into the access phase, then drop ready again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else if (access_wait) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !hit;
      prdata_ff  <= (hit && !req.write) ? rd_data : 32'h00000000;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // write lands on the edge where the master samples ready
  always_comb begin
    wr.stb  = req.sel && req.enable && pready_ff && req.write && hit;
    wr.idx  = pla_pkg::word_idx(req.addr);
    wr.data = req.wdata;
  end

endmodule

// ---- rtl/pla_top.sv ----
/*
  link partner ability register bank with its apb front end.
  holds the base page or, once both ends agree on next pages,
  the latest next page received from the remote partner.
  assumes the negotiation engine delivers each received page as a
  one-cycle strobe and pulses base_exchange_done on a good base exchange.
*/
// Notes on behaviour
// RQ1: base page abilities loaded, read at index 5
// RQ2: next pages replace contents when both support
// RQ3: bit 15 shows partner wants pages
// RQ4: bit 14 partner acknowledge, engine only, resets 0
// RQ5: bit 13 partner remote fault
// RQ6: bit 12 reserved, reads zero in base
// RQ7: bit 11 asymmetric pause ability
// RQ8: bit 10 symmetric pause ability
// RQ9: bit 9 four pair fast ability
// RQ10: bit 8 fast full duplex ability
// RQ11: bit 7 fast half duplex ability
// RQ12: bit 6 ten full duplex ability
// RQ13: bit 5 ten half duplex ability
// RQ14: bits 4..0 selector, zero until base received
// RQ15: next view bit 14 keeps acknowledge
// RQ16: next view bit 12 partner can comply
// RQ17: next view bit 11 toggle flag
// RQ18: next view bits 10..0 code field
// RQ19: software writes never change the abilities; a restart write clears them
`timescale 1ns/1ps
module pla_top (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [pla_pkg::ADDR_W-1:0] paddr,
  input  wire logic [pla_pkg::DATA_W-1:0] pwdata,
  output logic      [pla_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire pla_pkg::pla_page_t         rx_page,
  input  wire logic                       base_exchange_done,
  output logic      [pla_pkg::PAGE_W-1:0] partner_abilities_reg,
  output logic                            next_view_ff
);

  //////////////////////////////////////////////////////////////////////
  // declarations

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BASE = 3'b010,
    ST_NEXT = 3'b100
  } pla_view_t;

  pla_view_t                       state_ff;
  pla_view_t                       nxt_state;
  pla_pkg::pla_apb_req_t           req;
  pla_pkg::pla_wr_t                wr;
  pla_pkg::pla_base_t              base_in;
  pla_pkg::pla_next_t              next_in;
  logic [pla_pkg::PAGE_W-1:0]      abil_ff;
  logic [pla_pkg::PAGE_W-1:0]      nxt_abil;
  logic [pla_pkg::DATA_W-1:0]      rd_data;
  logic [pla_pkg::CNT_W-1:0]       pg_cnt_ff;
  logic                            pg_en_ff;
  logic                            restart_ff;
  logic                            base_seen_ff;
  logic                            take_base;
  logic                            take_next;
  logic                            ctrl_wr;

  //////////////////////////////////////////////////////////////////////
  // bus front end

  // bundle the apb pins for the slave
  always_comb begin
    req.sel    = psel;
    req.enable = penable;
    req.write  = pwrite;
    req.addr   = paddr;
    req.wdata  = pwdata;
  end

  pla_apb_slave u_slave (
    .pclk       (pclk),
    .presetn    (presetn),
    .req        (req),
    .rd_data    (rd_data),
    .prdata_ff  (prdata),
    .pready_ff  (pready),
    .pslverr_ff (pslverr),
    .wr         (wr)
  );

  assign ctrl_wr = wr.stb && (wr.idx == pla_pkg::CTRL_IDX);

  //////////////////////////////////////////////////////////////////////
  // control register

  // next page enable steers the view switch below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_en_ff <= pla_pkg::CTRL_PG_EN_RST;
    end else if (ctrl_wr) begin
      pg_en_ff <= wr.data[pla_pkg::CTRL_PG_EN];
    end
  end

  // restart is self clearing; it reads back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= ctrl_wr && wr.data[pla_pkg::CTRL_RESTART];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // page acceptance

  // base pages are ignored once the next page view is active, and
  // next pages are ignored until then, so a stray page cannot mix views
  assign take_base = rx_page.valid && !rx_page.next && (state_ff != ST_NEXT);
  assign take_next = rx_page.valid && rx_page.next && (state_ff == ST_NEXT);

  // split the received word into base fields
  always_comb begin
    base_in                        = rx_page.word;
    base_in.more_pages_wanted      = rx_page.word[15];      // RQ3
    base_in.ack                    = rx_page.word[14];      // RQ4
    base_in.partner_fault_flag     = rx_page.word[13];      // RQ5
    base_in.rsvd                   = 1'b0;                  // RQ6
    base_in.one_way_flow_ctrl_able = rx_page.word[11];      // RQ7
    base_in.pause_able             = rx_page.word[10];      // RQ8
    base_in.four_pair_fast_able    = rx_page.word[9];       // RQ9
    base_in.fast_full_able         = rx_page.word[8];       // RQ10
    base_in.fast_half_able         = rx_page.word[7];       // RQ11
    base_in.ten_full_able          = rx_page.word[6];       // RQ12
    base_in.ten_half_able          = rx_page.word[5];       // RQ13
    base_in.selector               = rx_page.word[4:0];     // RQ14
  end

  // split the received word into next page fields
  always_comb begin
    next_in                    = rx_page.word;
    next_in.more_pages_wanted  = rx_page.word[15];          // RQ3
    next_in.ack                = rx_page.word[14];          // RQ15
    next_in.message_page_flag  = rx_page.word[13];
    next_in.partner_can_comply = rx_page.word[12];          // RQ16
    next_in.toggle             = rx_page.word[11];          // RQ17
    next_in.code               = rx_page.word[10:0];        // RQ18
  end

  //////////////////////////////////////////////////////////////////////
  // view state machine

  // a page the current view accepts wins over a restart, so that page is not lost; a base page in the next page view is dropped
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (take_base) begin
          nxt_state = ST_BASE;
        end
      end
      ST_BASE: begin
        if (restart_ff && !take_base) begin
          nxt_state = ST_IDLE;
        end else if (base_exchange_done && pg_en_ff && abil_ff[pla_pkg::BIT_MORE_PAGES]) begin
          nxt_state = ST_NEXT; // RQ2
        end
      end
      ST_NEXT: begin
        // a next page that wins over restart must keep its view, or its
        // bit 12 would show up as a set reserved bit in the base view
        if (restart_ff && !take_next) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // view flag for the rest of the chip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_view_ff <= 1'b0;
    end else begin
      next_view_ff <= (nxt_state == ST_NEXT);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // ability register

  // the negotiation engine loads it and a restart clears it; bus writes to it are ignored
  always_comb begin
    nxt_abil = abil_ff;
    if (restart_ff) begin
      nxt_abil = pla_pkg::ABIL_RST;
    end
    if (take_base) begin
      nxt_abil = base_in;                                   // RQ1
    end else if (take_next) begin
      nxt_abil = next_in;                                   // RQ2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abil_ff <= pla_pkg::ABIL_RST;                         // RQ4
    end else begin
      abil_ff <= nxt_abil;                                  // RQ19
    end
  end

  assign partner_abilities_reg = abil_ff;

  //////////////////////////////////////////////////////////////////////
  // status bookkeeping

  // base seen flag; a fresh base page wins over restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_seen_ff <= 1'b0;
    end else if (take_base) begin
      base_seen_ff <= 1'b1;
    end else if (restart_ff) begin
      base_seen_ff <= 1'b0;
    end
  end

  // next pages counted; saturates so software never sees a wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_cnt_ff <= 8'h00;
    end else if (take_next) begin
      if (pg_cnt_ff != 8'hFF) begin
        pg_cnt_ff <= pg_cnt_ff + 8'h01;
      end
    end else if (restart_ff) begin
      pg_cnt_ff <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rd_data = 32'h00000000;
    unique case (pla_pkg::word_idx(paddr))
      pla_pkg::ABIL_IDX: begin
        rd_data[pla_pkg::PAGE_W-1:0] = abil_ff;             // RQ1
      end
      pla_pkg::CTRL_IDX: begin
        rd_data[pla_pkg::CTRL_PG_EN] = pg_en_ff;
      end
      pla_pkg::STAT_IDX: begin
        rd_data[pla_pkg::STAT_PG_VIEW] = (state_ff == ST_NEXT);
        rd_data[pla_pkg::STAT_BASE]    = base_seen_ff;
        rd_data[pla_pkg::STAT_CNT_LO +: pla_pkg::CNT_W] = pg_cnt_ff;
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_base_arrives;
    take_base && !take_next;
  endsequence

  sequence s_next_arrives;
    take_next;
  endsequence

  sequence s_switch_cond;
    (state_ff == ST_BASE) && base_exchange_done && pg_en_ff
      && abil_ff[pla_pkg::BIT_MORE_PAGES] && !restart_ff;
  endsequence

  a_base_load: assert property ( // RQ1
    s_base_arrives |=> abil_ff == ($past(rx_page.word) & 16'hEFFF)
  ) else $error("base page not loaded");

  a_rsvd_zero: assert property ( // RQ6
    (state_ff != ST_NEXT) |-> !abil_ff[pla_pkg::BIT_RSVD]
  ) else $error("reserved bit set in base view");

  a_view_switch: assert property ( // RQ2
    s_switch_cond |=> (state_ff == ST_NEXT) ##0 next_view_ff
  ) else $error("next page view not entered");

  a_next_load: assert property ( // RQ18
    s_next_arrives |=> abil_ff == $past(rx_page.word)
  ) else $error("next page not loaded");

  a_more_pages: assert property ( // RQ3
    (take_base || take_next) |=> abil_ff[15] == $past(rx_page.word[15])
  ) else $error("next page request bit wrong");

  a_ack_track: assert property ( // RQ4
    (take_base || take_next) |=> abil_ff[14] == $past(rx_page.word[14])
  ) else $error("acknowledge bit wrong");

  a_write_ignored: assert property ( // RQ19
    (wr.stb && wr.idx == pla_pkg::ABIL_IDX && !rx_page.valid && !restart_ff)
      |=> $stable(abil_ff)
  ) else $error("bus write changed abilities");

  a_read_answer: assert property ( // RQ1
    (psel && penable && !pready && !pwrite && paddr == pla_pkg::ABIL_ADDR)
      |=> pready && !pslverr && prdata == {16'h0000, $past(abil_ff)}
  ) else $error("ability read answer wrong");

  a_pg_hold_off: assert property ( // RQ2
    (rx_page.valid && rx_page.next && state_ff != ST_NEXT && !restart_ff)
      |=> $stable(abil_ff) [*2] or (take_base || restart_ff)
  ) else $error("next page accepted before switch");

endmodule

// ---- bench/test_partner_ability_register.sv ----
/*
  self-checking bench for the link partner ability register bank.
  assumes pla_top with an apb slave answering one cycle after the
  access phase starts, and one-cycle page and exchange strobes.
*/
`timescale 1ns/1ps
module test_partner_ability_register;

  logic                            pclk;
  logic                            presetn;
  logic                            psel;
  logic                            penable;
  logic                            pwrite;
  logic [pla_pkg::ADDR_W-1:0]      paddr;
  logic [pla_pkg::DATA_W-1:0]      pwdata;
  logic [pla_pkg::DATA_W-1:0]      prdata;
  logic                            pready;
  logic                            pslverr;
  pla_pkg::pla_page_t              rx_page;
  logic                            base_exchange_done;
  logic [pla_pkg::PAGE_W-1:0]      partner_abilities_reg;
  logic                            next_view_ff;
  int                              err_total;
  int                              checked;
  int                              cycles;
  logic [15:0]                     w;
  logic [15:0]                     pg_tab [4];

  pla_top pla_top_i (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .rx_page               (rx_page),
    .base_exchange_done    (base_exchange_done),
    .partner_abilities_reg (partner_abilities_reg),
    .next_view_ff          (next_view_ff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard: the ceiling is far above the real run length
  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparisons and verdict
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // apb transfer; pready is sampled at the edge itself, so the answer
  // is taken before that edge's own register updates land
  task automatic apb_chk(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                         input logic [31:0] expd, input logic expe);
    logic [31:0] d;
    logic        e;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff (pready === 1'b1));
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (!wr)
      cmp_word(d, expd);
    cmp_bit(e, expe);
  endtask

  // one received page, then a settled look at the register output
  task automatic send_page(input logic nx, input logic [15:0] wd);
    @(posedge pclk);
    rx_page <= {1'b1, nx, wd};
    @(posedge pclk);
    rx_page <= '0;
    #1;
  endtask

  task automatic exch_done;
    @(posedge pclk);
    base_exchange_done <= 1'b1;
    @(posedge pclk);
    base_exchange_done <= 1'b0;
    #1;
  endtask

  task automatic chk_reg(input logic [15:0] exp);
    cmp_word({16'h0000, partner_abilities_reg}, {16'h0000, exp});
    apb_chk(1'b0, 12'h014, 32'h0, {16'h0000, exp}, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rx_page = '0;
    base_exchange_done = 1'b0;
    err_total = 0;
    checked = 0;
    cycles = 0;
    pg_tab = '{16'hD800, 16'h3ABC, 16'h0001, 16'h57FF};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    // cleared state after reset
    cmp_bit(next_view_ff, 1'b0);
    chk_reg(16'h0000);
    // walk a single one through the base page; the reserved bit never shows
    for (int i = 0; i < 16; i++) begin
      w = 16'h0001 << i;
      send_page(1'b0, w);
      chk_reg(w & 16'hEFFF);
    end
    send_page(1'b0, 16'hFFFF);
    chk_reg(16'hEFFF);
    // software writes leave the abilities alone; bad addresses are refused
    apb_chk(1'b1, 12'h014, 32'h0000_0000, 32'h0, 1'b0);
    apb_chk(1'b1, 12'h044, 32'hFFFF_FFFF, 32'h0, 1'b0);
    chk_reg(16'hEFFF);
    apb_chk(1'b0, 12'h018, 32'h0, 32'h0, 1'b1);
    apb_chk(1'b0, 12'h015, 32'h0, 32'h0, 1'b1);
    // next page before any exchange is ignored
    send_page(1'b1, 16'h1234);
    chk_reg(16'hEFFF);
    // partner wants pages but local side does not: base view stays
    send_page(1'b0, 16'h8001);
    exch_done();
    cmp_bit(next_view_ff, 1'b0);
    send_page(1'b1, 16'h1234);
    chk_reg(16'h8001);
    // both ends want pages: next pages replace the base contents
    apb_chk(1'b1, 12'h040, 32'h0000_0001, 32'h0, 1'b0);
    apb_chk(1'b0, 12'h040, 32'h0, 32'h0000_0001, 1'b0);
    send_page(1'b0, 16'hC4E1);
    exch_done();
    cmp_bit(next_view_ff, 1'b1);
    chk_reg(16'hC4E1);
    foreach (pg_tab[k]) begin
      send_page(1'b1, pg_tab[k]);
      chk_reg(pg_tab[k]);
    end
    // a late base page cannot overwrite the next page view
    send_page(1'b0, 16'h0021);
    chk_reg(16'h57FF);
    apb_chk(1'b0, 12'h044, 32'h0, 32'h0000_0403, 1'b0);
    // restart drops the view and abilities back to the cleared base view, the same write clears page enable; the strobe
    // is registered, so its effect shows one edge after the write lands
    apb_chk(1'b1, 12'h040, 32'h0000_0002, 32'h0, 1'b0);
    @(posedge pclk);
    #1;
    cmp_bit(next_view_ff, 1'b0);
    chk_reg(16'h0000);
    end_of_test();
  end

endmodule
